/* File: pxc_params.svh */
// Register offsets, field positions, reset values and timing counts of the routing block.
`ifndef PXC_PARAMS_SVH
`define PXC_PARAMS_SVH
`define PXC_A_CTRL 8'h00
`define PXC_A_GRANT 8'h04
`define PXC_A_MULT 8'h08
`define PXC_A_DIV 8'h0C
`define PXC_A_STAR_DIR 8'h10
`define PXC_A_STAR_OUT 8'h14
`define PXC_A_STAR_IN 8'h18
`define PXC_A_STATUS 8'h1C
`define PXC_C_EXT 0
`define PXC_C_BPREF 1
`define PXC_C_STAR_EN 2
`define PXC_C_DIO_HI 3
`define PXC_C_T7_DRV 4
`define PXC_C_T7_VAL 5
`define PXC_C_REF_DRV 6
`define PXC_C_TSEL_LO 8
`define PXC_C_TSEL_HI 9
`define PXC_G_STAR 0
`define PXC_G_T7 1
`define PXC_G_REFRX 2
`define PXC_G_REFTX 3
`define PXC_S_ERR 0
`define PXC_S_SLOT2 1
`define PXC_S_T7_IN 2
`define PXC_S_STAR_IN 3
`define PXC_CTRL_RST 10'h000
`define PXC_GRANT_RST 4'h0
`define PXC_MULT_RST 16'h0028
`define PXC_MULT_MIN 16'h0028
`define PXC_DIV_RST 16'h0001
`define PXC_EXT_DIV 64
`define PXC_SLOTS 13
`define PXC_CLK_PERIOD_NS 4
`define PXC_REF_PERIOD_NS 100
`define PXC_REF_HALF_CYC ((`PXC_REF_PERIOD_NS / 2) / `PXC_CLK_PERIOD_NS)
`endif

/* File: pxc_pkg.sv */
// Types shared by the clock and trigger routing block.
package pxc_pkg;
   typedef enum logic [1:0] {
      PXC_TS_NONE,
      PXC_TS_STAR,
      PXC_TS_BUS7,
      PXC_TS_EXT
   } pxc_tsel_t;
   typedef enum logic [1:0] {
      PXC_TB_INT,
      PXC_TB_BPREF,
      PXC_TB_EXT
   } pxc_tbase_t;
endpackage : pxc_pkg

/* File: pxc_routing.sv */
// Sampling clock selection and backplane trigger and clock routing.
//
// Function
// - External clock mode gives one sample per 64 external clock cycles.
// - Sample clock shares the counter two external clock pin.
// - Internal mode: counter clock is M times sample rate, M 40..65535.
// - Star trigger and upper digital lines never active together.
// - Star controller slot drives or senses each of thirteen slots individually.
// - In a peripheral slot, star input is a selectable trigger source.
// - Bussed trigger seven may be driven or sensed, released from power-up.
// - Bussed trigger lines six to zero are never connected.
// - Left neighbour lines released at power-up; drive refused outside slot two.
// - Right local bus lines are never connected or driven.
// - Backplane 10 MHz reference may be the conversion clock timebase.
// - In star slot, a reference clock may be driven onto the backplane.
// - Drivers stay off until granted; ungranted access other than sensing bussed trigger seven, the star input or the star lines flags an error.
`timescale 1ns/10ps
`include "pxc_params.svh"

module pxc_routing #(
   parameter int SLOTS = `PXC_SLOTS,
   parameter int EXT_DIV = `PXC_EXT_DIV,
   parameter int REF_HALF = `PXC_REF_HALF_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   input wire logic counter_two_ext_clock_pin,
   // Register port.
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Slot and backplane inputs.
   input wire logic slot_two_pin,
   input wire logic bp_ref_in,
   input wire logic ext_trig_pin,
   input wire logic star_pin_in,
   input wire logic bus7_in,
   input wire logic [SLOTS-1:0] left_neighbor_lines_in,
   // Backplane drivers.
   output logic bus7_out,
   output logic bus7_oe,
   output logic [SLOTS-1:0] left_neighbor_lines_out,
   output logic [SLOTS-1:0] left_neighbor_lines_oe,
   output logic ref_out,
   output logic ref_oe,
   // Timing and trigger outputs.
   output logic ai_sample,
   output logic ctr_clk_tick,
   output logic trig_pulse,
   output logic dio_hi_en,
   output logic err_flag
);

   localparam int NIN = SLOTS + 5;
   localparam int EW = $clog2(EXT_DIV);
   // Pulled-up lines reset to their idle high level, so leaving reset shows no false edge.
   localparam logic [NIN-1:0] PIN_IDLE = {5'b00011, {SLOTS{1'b1}}};

   ////////////////////////////////////////////////////////////////////////////////
   // Pin input filtering: three flops, a change counts once stages two and three agree.
   logic [NIN-1:0] pin_raw;
   logic [NIN-1:0] s1_r;
   logic [NIN-1:0] s2_r;
   logic [NIN-1:0] s3_r;
   logic [NIN-1:0] filt_r;
   logic [NIN-1:0] filt_d_r;

   assign pin_raw = {slot_two_pin, bp_ref_in, ext_trig_pin, star_pin_in, bus7_in,
                     left_neighbor_lines_in};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= PIN_IDLE;
         s2_r <= PIN_IDLE;
         s3_r <= PIN_IDLE;
         filt_r <= PIN_IDLE;
         filt_d_r <= PIN_IDLE;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
         filt_d_r <= filt_r;
      end
   end

   logic in_slot2;
   logic ref_rise;
   logic ext_rise;
   logic star_rise;
   logic bus7_rise;
   logic [SLOTS-1:0] star_lines;

   assign star_lines = filt_r[SLOTS-1:0];
   assign in_slot2 = filt_r[SLOTS+4];
   assign ref_rise = filt_r[SLOTS+3] & ~filt_d_r[SLOTS+3];
   assign ext_rise = filt_r[SLOTS+2] & ~filt_d_r[SLOTS+2];
   assign star_rise = filt_r[SLOTS+1] & ~filt_d_r[SLOTS+1];
   assign bus7_rise = filt_r[SLOTS] & ~filt_d_r[SLOTS];

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: the external clock is divided down where it lives.
   logic [EW-1:0] ext_cnt_r;
   logic ext_tog_r;

   always_ff @(posedge counter_two_ext_clock_pin or negedge rstn) begin
      if (!rstn) begin
         ext_cnt_r <= '0;
         ext_tog_r <= 1'b0;
      end else begin
         ext_cnt_r <= ext_cnt_r + 1'b1;
         if (ext_cnt_r == EW'(EXT_DIV - 1)) begin
            ext_tog_r <= ~ext_tog_r;
         end
      end
   end
   a_ext_div: assert property (@(posedge counter_two_ext_clock_pin) disable iff (!rstn)
      (ext_cnt_r == EW'(EXT_DIV - 1)) |=> (ext_tog_r != $past(ext_tog_r)))
      else $error("External divider did not toggle at wrap.");

   // The toggle crosses as an event; a stopped external clock simply yields no samples.
   logic t1_r;
   logic t2_r;
   logic t3_r;
   logic tf_r;
   logic ext_tick;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         t1_r <= 1'b0;
         t2_r <= 1'b0;
         t3_r <= 1'b0;
         tf_r <= 1'b0;
      end else begin
         t1_r <= ext_tog_r;
         t2_r <= t1_r;
         t3_r <= t2_r;
         if (t2_r == t3_r) begin
            tf_r <= t3_r;
         end
      end
   end

   assign ext_tick = (t2_r == t3_r) && (t3_r != tf_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [9:0] ctrl_r;
   logic [3:0] grant_r;
   logic [15:0] mult_r;
   logic [15:0] div_r;
   logic [SLOTS-1:0] star_dir_r;
   logic [SLOTS-1:0] star_out_r;
   logic err_nxt;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit
   always_comb begin
      err_nxt = 1'b0;
      if (wr && hit(addr, `PXC_A_CTRL)) begin
         if ((wdata[`PXC_C_STAR_EN] && !grant_r[`PXC_G_STAR]) ||
             (wdata[`PXC_C_T7_DRV] && !grant_r[`PXC_G_T7]) ||
             (wdata[`PXC_C_BPREF] && !grant_r[`PXC_G_REFRX]) ||
             (wdata[`PXC_C_REF_DRV] && (!grant_r[`PXC_G_REFTX] || !in_slot2)) ||
             (wdata[`PXC_C_STAR_EN] && wdata[`PXC_C_DIO_HI])) begin
            err_nxt = 1'b1;
         end
      end
      if (wr && hit(addr, `PXC_A_STAR_DIR) && (wdata[SLOTS-1:0] != '0) &&
          (!in_slot2 || !grant_r[`PXC_G_STAR])) begin
         err_nxt = 1'b1;
      end
      if (wr && hit(addr, `PXC_A_MULT) && (wdata[15:0] < `PXC_MULT_MIN)) begin
         err_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `PXC_CTRL_RST;
         grant_r <= `PXC_GRANT_RST;
         mult_r <= `PXC_MULT_RST;
         div_r <= `PXC_DIV_RST;
         star_dir_r <= '0;
         star_out_r <= '0;
      end else if (wr && !err_nxt) begin
         if (hit(addr, `PXC_A_CTRL)) begin
            ctrl_r <= wdata[9:0];
         end
         if (hit(addr, `PXC_A_GRANT)) begin
            grant_r <= wdata[3:0];
         end
         if (hit(addr, `PXC_A_MULT)) begin
            mult_r <= wdata[15:0];
         end
         if (hit(addr, `PXC_A_DIV)) begin
            div_r <= (wdata[15:0] == '0) ? 16'h0001 : wdata[15:0];
         end
         if (hit(addr, `PXC_A_STAR_DIR)) begin
            star_dir_r <= wdata[SLOTS-1:0];
         end
         if (hit(addr, `PXC_A_STAR_OUT)) begin
            star_out_r <= wdata[SLOTS-1:0];
         end
      end
   end
   a_mult_min: assert property (@(posedge clk) disable iff (!rstn)
      mult_r >= `PXC_MULT_MIN)
      else $error("Multiplier fell below its minimum.");

   // Error is sticky; a write of one clears it, but a new error in that cycle wins.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         err_flag <= 1'b0;
      end else if (err_nxt) begin
         err_flag <= 1'b1;
      end else if (wr && hit(addr, `PXC_A_STATUS) && wdata[`PXC_S_ERR]) begin
         err_flag <= 1'b0;
      end
   end
   a_err_set: assert property (@(posedge clk) disable iff (!rstn)
      (wr && hit(addr, `PXC_A_CTRL) && wdata[`PXC_C_T7_DRV] && !grant_r[`PXC_G_T7])
      |=> err_flag && $stable(ctrl_r))
      else $error("Ungranted write was not refused with an error.");

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         case (addr)
            `PXC_A_CTRL: rdata <= {22'h000000, ctrl_r};
            `PXC_A_GRANT: rdata <= {28'h0000000, grant_r};
            `PXC_A_MULT: rdata <= {16'h0000, mult_r};
            `PXC_A_DIV: rdata <= {16'h0000, div_r};
            `PXC_A_STAR_DIR: rdata <= 32'(star_dir_r);
            `PXC_A_STAR_OUT: rdata <= 32'(star_out_r);
            `PXC_A_STAR_IN: rdata <= 32'(star_lines);
            `PXC_A_STATUS: rdata <= {28'h0000000, filt_r[SLOTS+1], filt_r[SLOTS],
                                    in_slot2, err_flag};
            default: rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timebase and sample clock generation.
   pxc_pkg::pxc_tbase_t tbase;
   logic [15:0] div_cnt_r;
   logic [15:0] m_cnt_r;
   logic tb_tick;
   logic ctr_tick;

   always_comb begin
      if (ctrl_r[`PXC_C_EXT]) begin
         tbase = pxc_pkg::PXC_TB_EXT;
      end else if (ctrl_r[`PXC_C_BPREF] && grant_r[`PXC_G_REFRX]) begin
         tbase = pxc_pkg::PXC_TB_BPREF;
      end else begin
         tbase = pxc_pkg::PXC_TB_INT;
      end
   end

   assign tb_tick = (tbase == pxc_pkg::PXC_TB_BPREF) ? ref_rise : 1'b1;
   assign ctr_tick = tb_tick && (div_cnt_r == div_r - 16'h0001);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_cnt_r <= '0;
         m_cnt_r <= '0;
      end else begin
         if (tb_tick) begin
            div_cnt_r <= ctr_tick ? 16'h0000 : div_cnt_r + 16'h0001;
         end
         if (ctr_tick) begin
            m_cnt_r <= (m_cnt_r >= mult_r - 16'h0001) ? 16'h0000 : m_cnt_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ai_sample <= 1'b0;
         ctr_clk_tick <= 1'b0;
      end else if (tbase == pxc_pkg::PXC_TB_EXT) begin
         ai_sample <= ext_tick;
         ctr_clk_tick <= 1'b0;
      end else begin
         ai_sample <= ctr_tick && (m_cnt_r >= mult_r - 16'h0001);
         ctr_clk_tick <= ctr_tick;
      end
   end
   a_sample_m: assert property (@(posedge clk) disable iff (!rstn)
      (ai_sample && !$past(ctrl_r[`PXC_C_EXT])) |-> $past(ctr_tick))
      else $error("Internal sample without a counter clock tick.");

   ////////////////////////////////////////////////////////////////////////////////
   // Backplane drivers, all released until reset ends and a grant is given.
   logic star_mode;
   logic [$clog2(REF_HALF+1)-1:0] ref_cnt_r;

   assign star_mode = ctrl_r[`PXC_C_STAR_EN] && grant_r[`PXC_G_STAR];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left_neighbor_lines_oe <= '0;
         left_neighbor_lines_out <= '0;
         dio_hi_en <= 1'b0;
      end else begin
         left_neighbor_lines_oe <= (star_mode && in_slot2) ? star_dir_r : '0;
         left_neighbor_lines_out <= star_out_r;
         dio_hi_en <= ctrl_r[`PXC_C_DIO_HI] && !star_mode;
      end
   end
   a_lbl_slot: assert property (@(posedge clk) disable iff (!rstn)
      (left_neighbor_lines_oe != '0) |-> $past(in_slot2 && grant_r[`PXC_G_STAR]))
      else $error("Left lines driven outside slot two or without grant.");
   a_dio_excl: assert property (@(posedge clk) disable iff (!rstn)
      !(dio_hi_en && (left_neighbor_lines_oe != '0)))
      else $error("Star lines and upper digital lines active together.");

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus7_oe <= 1'b0;
         bus7_out <= 1'b0;
      end else begin
         bus7_oe <= ctrl_r[`PXC_C_T7_DRV] && grant_r[`PXC_G_T7];
         bus7_out <= ctrl_r[`PXC_C_T7_VAL];
      end
   end
   a_bus7_grant: assert property (@(posedge clk) disable iff (!rstn)
      bus7_oe |-> $past(grant_r[`PXC_G_T7]))
      else $error("Bussed trigger driven without grant.");

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_cnt_r <= '0;
         ref_out <= 1'b0;
         ref_oe <= 1'b0;
      end else begin
         ref_oe <= ctrl_r[`PXC_C_REF_DRV] && grant_r[`PXC_G_REFTX] && in_slot2;
         if (ref_cnt_r == ($clog2(REF_HALF+1))'(REF_HALF - 1)) begin
            ref_cnt_r <= '0;
            ref_out <= ~ref_out;
         end else begin
            ref_cnt_r <= ref_cnt_r + 1'b1;
         end
      end
   end
   a_ref_oe: assert property (@(posedge clk) disable iff (!rstn)
      ref_oe |-> $past(in_slot2 && grant_r[`PXC_G_REFTX]))
      else $error("Reference driven outside star slot or without grant.");

   ////////////////////////////////////////////////////////////////////////////////
   // Trigger source selection.
   pxc_pkg::pxc_tsel_t tsel;

   assign tsel = pxc_pkg::pxc_tsel_t'(ctrl_r[`PXC_C_TSEL_HI:`PXC_C_TSEL_LO]);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         trig_pulse <= 1'b0;
      end else begin
         case (tsel)
            pxc_pkg::PXC_TS_STAR: trig_pulse <= star_rise;
            pxc_pkg::PXC_TS_BUS7: trig_pulse <= bus7_rise && grant_r[`PXC_G_T7];
            pxc_pkg::PXC_TS_EXT: trig_pulse <= ext_rise;
            default: trig_pulse <= 1'b0;
         endcase
      end
   end
   a_trig_star: assert property (@(posedge clk) disable iff (!rstn)
      (tsel == pxc_pkg::PXC_TS_STAR && star_rise) |=> trig_pulse)
      else $error("Star input edge did not raise a trigger.");

endmodule : pxc_routing

/* File: pxc_bp_model.sv */
// Backplane model: slot drivers, pull-ups and the shared reference clock.
`timescale 1ns/10ps

module pxc_bp_model #(
   parameter int SLOTS = 13
) (
   // Bench controls.
   input wire logic rstn,
   input wire logic star_kick,
   input wire logic bus7_kick,
   input wire logic [SLOTS-1:0] slot_val,
   // Device drivers.
   input wire logic bus7_out,
   input wire logic bus7_oe,
   input wire logic [SLOTS-1:0] lines_out,
   input wire logic [SLOTS-1:0] lines_oe,
   input wire logic ref_out,
   input wire logic ref_oe,
   // Lines seen by the device.
   output logic bp_ref_in,
   output logic star_pin_in,
   output logic bus7_in,
   output logic [SLOTS-1:0] lines_in
);
   logic ref10;

   initial begin
      ref10 = 1'b0;
      #0.7;
      forever #50 ref10 = ~ref10;
   end

   assign bp_ref_in = ref_oe ? ref_out : ref10;
   // Slots silent in reset.
   // Released lines show slot_val out of reset and their pull-ups in reset, so a stale value can never pass for a drive.
   assign lines_in = (lines_oe & lines_out) | (~lines_oe & (rstn ? slot_val : '1));
   assign star_pin_in = rstn ? ~star_kick : 1'b1;
   assign bus7_in = bus7_oe ? bus7_out : ~bus7_kick;
endmodule : pxc_bp_model

/* File: pxc_routing_tb.sv */
// Self-checking bench for the clock and trigger routing block.
`timescale 1ns/10ps
`include "pxc_params.svh"

module pxc_routing_tb;
   logic clk, rstn, ext_clk, ext_run, ext_trig, slot2, wr, rd, star_kick, bus7_kick;
   logic rd_q = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, seed, dir, sout, m, d;
   logic [12:0] slot_val, lin, lno, lnoe;
   logic bp_ref, star_in, b7_in, b7_out, b7_oe, ref_out, ref_oe;
   logic ai_sample, ctr_tick, trig_pulse, dio_hi_en, err_flag;
   logic [31:0] expq[$];
   int fails, total_checks, ext_cnt, trig_cnt, cyc, ticks, exts;
   time t0;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // The link clock only runs inside a measurement, as a real source would be gated.
   initial begin
      ext_clk = 1'b0;
      #1.3;
      forever #80 ext_clk = ext_run ? ~ext_clk : 1'b0;
   end

   always @(posedge ext_clk) ext_cnt++;
   always @(posedge clk) if (trig_pulse === 1'b1) trig_cnt++;

   ////////////////////////////////////////////////////////////////////////////////
   pxc_routing uut (.clk(clk), .rstn(rstn), .counter_two_ext_clock_pin(ext_clk), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .slot_two_pin(slot2), .bp_ref_in(bp_ref),
      .ext_trig_pin(ext_trig), .star_pin_in(star_in), .bus7_in(b7_in),
      .left_neighbor_lines_in(lin), .bus7_out(b7_out), .bus7_oe(b7_oe),
      .left_neighbor_lines_out(lno), .left_neighbor_lines_oe(lnoe), .ref_out(ref_out),
      .ref_oe(ref_oe), .ai_sample(ai_sample), .ctr_clk_tick(ctr_tick),
      .trig_pulse(trig_pulse), .dio_hi_en(dio_hi_en), .err_flag(err_flag));

   pxc_bp_model #(.SLOTS(13)) bp (.rstn(rstn), .star_kick(star_kick), .bus7_kick(bus7_kick),
      .slot_val(slot_val), .bus7_out(b7_out), .bus7_oe(b7_oe), .lines_out(lno),
      .lines_oe(lnoe), .ref_out(ref_out), .ref_oe(ref_oe), .bp_ref_in(bp_ref),
      .star_pin_in(star_in), .bus7_in(b7_in), .lines_in(lin));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_reg

   task automatic refused(input logic [7:0] a, input logic [31:0] v);
      wr_reg(a, v);
      idle(2);
      chk(32'(err_flag), 32'h1);
      wr_reg(`PXC_A_STATUS, 32'h1);
      idle(2);
      chk(32'(err_flag), 32'h0);
   endtask : refused

   // Skips two sample intervals so a mode change never shortens the measured one.
   task automatic span();
      int e0;
      repeat (2) begin
         cyc = 0;
         do begin
            @(posedge clk);
            cyc++;
         end while (ai_sample !== 1'b1 && cyc < 20000);
      end
      e0 = ext_cnt;
      cyc = 0;
      ticks = 0;
      do begin
         @(posedge clk);
         cyc++;
         ticks += int'(ctr_tick === 1'b1);
      end while (ai_sample !== 1'b1 && cyc < 20000);
      exts = ext_cnt - e0;
   endtask : span

   task results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results

   // Read data are compared in the one cycle where they stand.
   always @(posedge clk) begin
      if (rd_q === 1'b1) begin
         chk(rdata, expq.pop_front());
      end
      rd_q <= rd;
   end

   initial begin
      #200000;
      fails++;
      results();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      ext_run = 1'b0;
      ext_trig = 1'b0;
      slot2 = 1'b0;
      star_kick = 1'b0;
      bus7_kick = 1'b0;
      seed = 32'hE2AF;
      slot_val = seed[12:0];
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      idle(2);
      chk(32'({b7_oe, ref_oe, lnoe}), 32'h0);
      rd_reg(`PXC_A_CTRL, 32'h0);
      rd_reg(`PXC_A_GRANT, 32'h0);
      rd_reg(`PXC_A_MULT, 32'h28);
      rd_reg(`PXC_A_STAR_DIR, 32'h0);
      rd_reg(8'h20, 32'h0);
      $display("defaults done");
      refused(`PXC_A_CTRL, 32'h4);
      refused(`PXC_A_CTRL, 32'h10);
      refused(`PXC_A_CTRL, 32'h2);
      refused(`PXC_A_MULT, 32'h27);
      wr_reg(`PXC_A_GRANT, 32'hF);
      refused(`PXC_A_STAR_DIR, 32'h1);
      refused(`PXC_A_CTRL, 32'h40);
      rd_reg(`PXC_A_CTRL, 32'h0);
      $display("refusals done");
      slot2 <= 1'b1;
      idle(8);
      rd_reg(`PXC_A_STATUS, 32'hE);
      refused(`PXC_A_CTRL, 32'hC);
      wr_reg(`PXC_A_CTRL, 32'h4);
      seed = lfsr(seed);
      dir = {19'h0, seed[12:0] | 13'h1};
      seed = lfsr(seed);
      sout = {19'h0, seed[12:0]};
      wr_reg(`PXC_A_STAR_DIR, dir);
      wr_reg(`PXC_A_STAR_OUT, sout);
      idle(8);
      chk(32'(dio_hi_en), 32'h0);
      chk(32'(lnoe), dir);
      chk(32'(lno) & dir, sout & dir);
      rd_reg(`PXC_A_STAR_IN, (dir & sout) | (~dir & 32'(slot_val)));
      wr_reg(`PXC_A_CTRL, 32'h8);
      idle(3);
      chk(32'({dio_hi_en, lnoe}), 32'h2000);
      wr_reg(`PXC_A_CTRL, 32'h30);
      idle(3);
      chk(32'({b7_oe, b7_out}), 32'h3);
      $display("star and bus done");
      for (int t = 0; t < 4; t++) begin
         wr_reg(`PXC_A_CTRL, 32'(t) << 8);
         idle(8);
         trig_cnt = 0;
         star_kick <= (t < 2);
         bus7_kick <= (t == 2);
         ext_trig <= (t == 3);
         idle(8);
         star_kick <= 1'b0;
         bus7_kick <= 1'b0;
         ext_trig <= 1'b0;
         idle(12);
         chk(32'(trig_cnt), 32'(t != 0));
      end
      $display("triggers done");
      seed = lfsr(seed);
      m = 32'd40 + 32'(seed[3:0]);
      d = 32'd2 + 32'(seed[5:4]);
      wr_reg(`PXC_A_CTRL, 32'h0);
      wr_reg(`PXC_A_MULT, m);
      wr_reg(`PXC_A_DIV, d);
      span();
      chk(32'(cyc), m * d);
      chk(32'(ticks), m);
      wr_reg(`PXC_A_MULT, 32'h28);
      wr_reg(`PXC_A_DIV, 32'h1);
      wr_reg(`PXC_A_CTRL, 32'h2);
      span();
      chk(32'(cyc), 32'd1000);
      ext_run <= 1'b1;
      wr_reg(`PXC_A_CTRL, 32'h1);
      span();
      chk(32'(exts), 32'd64);
      chk(32'(ticks), 32'd0);
      ext_run <= 1'b0;
      $display("timebases done");
      wr_reg(`PXC_A_CTRL, 32'h44);
      idle(3);
      chk(32'(ref_oe), 32'h1);
      @(posedge ref_out);
      t0 = $time;
      @(posedge ref_out);
      chk(32'(($time - t0) / 4), 32'd24);
      @(posedge clk);
      rstn <= 1'b0;
      idle(2);
      chk(32'({b7_oe, ref_oe, lnoe}), 32'h0);
      rstn <= 1'b1;
      idle(2);
      rd_reg(`PXC_A_CTRL, 32'h0);
      rd_reg(`PXC_A_STAR_DIR, 32'h0);
      idle(4);
      $display("reset done");
      results();
   end
endmodule : pxc_routing_tb
